// ### include/gcd_pkg.sv
// constants, types and encodings shared by the column driver design
package gcd_pkg;

  // geometry of the panel slice and the bit-map store
  localparam int PIXELS         = 160;
  localparam int LINES          = 240;
  localparam int MIN_DUTY       = 64;
  localparam int PIX_PER_BYTE   = 4;
  localparam int BITS_PER_PIXEL = 2;
  localparam int BYTES_PER_LINE = PIXELS / PIX_PER_BYTE;
  localparam int RAM_WORDS      = LINES * BYTES_PER_LINE;
  localparam int RAM_AW         = 14;
  localparam int FETCH_IDX_W    = 6;

  // host bus layout
  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 8;
  localparam int LINE_FIELD_W   = 9;
  localparam int LINE_FIELD_LSB = 7;
  localparam int COL_FIELD_W    = 7;
  localparam int COL_FIELD_LSB  = 0;

  // address windows picked by the two identity inputs
  localparam logic [COL_FIELD_W-1:0]  COL_WINDOW_BASE  = 7'h40;
  localparam logic [LINE_FIELD_W-1:0] LINE_WINDOW_BASE = 9'h100;
  localparam logic [LINE_FIELD_W-1:0] LINE_FIELD_ZERO  = 9'h000;
  localparam logic [COL_FIELD_W-1:0]  COL_FIELD_ZERO   = 7'h00;

  // frame dither sequencing: three frame phases
  localparam int FRAME_PHASES = 3;
  localparam int PHASE_W      = 2;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST  = 2'h2;
  localparam logic [FRAME_PHASES-1:0] GRAY1_PATTERN = 3'h1;
  localparam logic [FRAME_PHASES-1:0] GRAY2_PATTERN = 3'h3;

  // gray codes held in a pixel
  localparam logic [BITS_PER_PIXEL-1:0] GRAY_OFF  = 2'h0;
  localparam logic [BITS_PER_PIXEL-1:0] GRAY_ONE  = 2'h1;
  localparam logic [BITS_PER_PIXEL-1:0] GRAY_TWO  = 2'h2;
  localparam logic [BITS_PER_PIXEL-1:0] GRAY_FULL = 2'h3;

  // drive level chosen per column output
  typedef enum logic [1:0] {
    GCD_SELECT_HIGH   = 2'h0,
    GCD_SELECT_LOW    = 2'h1,
    GCD_DESELECT_HIGH = 2'h2,
    GCD_DESELECT_LOW  = 2'h3
  } gcd_level_e;

  typedef enum logic [0:0] {
    GCD_FETCH_IDLE = 1'b0,
    GCD_FETCH_BUSY = 1'b1
  } gcd_fetch_e;

  // host pins as sampled, strobes active low
  typedef struct packed {
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gcd_host_req_s;

  // one cycle of store access after arbitration
  typedef struct packed {
    logic              wr;
    logic [RAM_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gcd_ram_req_s;

endpackage : gcd_pkg

// ### hw/gcd_ram.sv
// single port bit-map store with registered read data
`timescale 1ns/1ps
`default_nettype none
module gcd_ram #(
  parameter int WORDS = gcd_pkg::RAM_WORDS
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire gcd_pkg::gcd_ram_req_s req,
  output logic [gcd_pkg::DATA_W-1:0] rdata
);

  logic [gcd_pkg::DATA_W-1:0] mem [WORDS];

  if (WORDS > (1 << gcd_pkg::RAM_AW)) begin : g_bad_words
    $error("gcd_ram: WORDS exceeds address width");
  end

  // static store, no clear: contents survive blanking
  always_ff @(posedge clk) begin
    if (req.wr && (int'(req.addr) < WORDS)) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // read returns the addressed word one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (int'(req.addr) < WORDS) begin
      rdata <= mem[req.addr];
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : gcd_ram
`default_nettype wire

// ### hw/gcd_frc_pixel.sv
// frame dither: one 2-bit gray value to an on/off state for this frame
`timescale 1ns/1ps
`default_nettype none
module gcd_frc_pixel (
  input  wire logic [gcd_pkg::BITS_PER_PIXEL-1:0] gray,
  input  wire logic [gcd_pkg::PHASE_W-1:0]        phase,
  output logic                                    on
);

  // the intermediate levels are lit in a fixed share of frames
  always_comb begin
    case (gray)
      gcd_pkg::GRAY_OFF:  on = 1'b0;
      gcd_pkg::GRAY_ONE:  on = gcd_pkg::GRAY1_PATTERN[phase];
      gcd_pkg::GRAY_TWO:  on = gcd_pkg::GRAY2_PATTERN[phase];
      gcd_pkg::GRAY_FULL: on = 1'b1;
      default:            on = 1'b0;
    endcase
  end

endmodule : gcd_frc_pixel
`default_nettype wire

// ### hw/gcd_column_driver.sv
// grayscale column driver with internal bit-map store and host draw port
`timescale 1ns/1ps
`default_nettype none
module gcd_column_driver #(
  parameter int PIXELS = gcd_pkg::PIXELS,
  parameter int LINES  = gcd_pkg::LINES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire gcd_pkg::gcd_host_req_s       host_req,
  output logic [gcd_pkg::DATA_W-1:0]        host_data_out,
  output logic                              host_data_oe,
  input  wire logic                         id_select_bit0,
  input  wire logic                         id_select_bit1,
  input  wire logic                         column_order_reverse,
  input  wire logic                         frame_start_marker,
  input  wire logic                         line_transfer_clock,
  input  wire logic                         ac_phase,
  input  wire logic                         display_blank_n,
  output logic [PIXELS*2-1:0]               column_outputs,
  output logic                              refresh_overrun
);

  localparam int BYTES = PIXELS / gcd_pkg::PIX_PER_BYTE;
  localparam int PPB   = gcd_pkg::PIX_PER_BYTE;
  localparam int BPP   = gcd_pkg::BITS_PER_PIXEL;

  // elaboration checks: geometry must fit the fixed address fields
  if ((PIXELS % PPB) != 0 || BYTES > (1 << gcd_pkg::FETCH_IDX_W)) begin : g_bad_pix
    $error("gcd_column_driver: PIXELS unsupported");
  end
  if (BYTES > int'(gcd_pkg::COL_WINDOW_BASE)) begin : g_bad_cols
    $error("gcd_column_driver: column window overlap");
  end
  if (LINES < gcd_pkg::MIN_DUTY || LINES > int'(gcd_pkg::LINE_WINDOW_BASE))
  begin : g_bad_lines
    $error("gcd_column_driver: LINES unsupported");
  end
  if (LINES * BYTES > (1 << gcd_pkg::RAM_AW)) begin : g_bad_ram
    $error("gcd_column_driver: store too large");
  end

  // timing input edge detection (pins are synchronous to clk)
  logic xfer_d_reg;
  logic marker_d_reg;
  logic xfer_fall;
  logic marker_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_d_reg   <= 1'b0;
      marker_d_reg <= 1'b0;
    end else begin
      xfer_d_reg   <= line_transfer_clock;
      marker_d_reg <= frame_start_marker;
    end
  end

  assign xfer_fall   = xfer_d_reg & ~line_transfer_clock;
  assign marker_rise = frame_start_marker & ~marker_d_reg;

  // host address decode
  logic [gcd_pkg::LINE_FIELD_W-1:0] line_field;
  logic [gcd_pkg::COL_FIELD_W-1:0]  col_field;
  logic [gcd_pkg::LINE_FIELD_W-1:0] line_base;
  logic [gcd_pkg::COL_FIELD_W-1:0]  col_base;
  logic [gcd_pkg::LINE_FIELD_W-1:0] line_off;
  logic [gcd_pkg::COL_FIELD_W-1:0]  col_off;
  logic                             addr_hit;
  logic                             selected;
  logic                             host_wr;
  logic                             host_rd;
  logic                             host_busy;
  logic [gcd_pkg::RAM_AW-1:0]       host_word;

  assign line_field = host_req.addr[gcd_pkg::LINE_FIELD_LSB +:
                                    gcd_pkg::LINE_FIELD_W];
  assign col_field  = host_req.addr[gcd_pkg::COL_FIELD_LSB +:
                                    gcd_pkg::COL_FIELD_W];

  // each identity owns one quadrant of the line/column field space
  assign line_base = id_select_bit1 ? gcd_pkg::LINE_WINDOW_BASE
                                    : gcd_pkg::LINE_FIELD_ZERO;
  assign col_base  = id_select_bit0 ? gcd_pkg::COL_WINDOW_BASE
                                    : gcd_pkg::COL_FIELD_ZERO;
  assign line_off  = line_field - line_base;
  assign col_off   = col_field - col_base;

  assign addr_hit = (line_field >= line_base)
                  && (line_off < gcd_pkg::LINE_FIELD_W'(LINES))
                  && (col_field >= col_base)
                  && (col_off < gcd_pkg::COL_FIELD_W'(BYTES));

  assign selected  = ~host_req.cs_n & addr_hit;
  assign host_wr   = selected & ~host_req.we_n;
  // write strobe takes precedence when both strobes are low
  assign host_rd   = selected & ~host_req.oe_n & host_req.we_n;
  assign host_busy = host_wr | host_rd;

  assign host_word = gcd_pkg::RAM_AW'(line_off) * gcd_pkg::RAM_AW'(BYTES)
                   + gcd_pkg::RAM_AW'(col_off);

  // line counter and frame phase
  logic [gcd_pkg::LINE_FIELD_W-1:0] line_cnt_reg;
  logic [gcd_pkg::PHASE_W-1:0]      phase_reg;

  // counter wraps at LINES so any marker spacing up to LINES works
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_cnt_reg <= gcd_pkg::LINE_FIELD_ZERO;
    end else if (frame_start_marker) begin
      line_cnt_reg <= gcd_pkg::LINE_FIELD_ZERO;
    end else if (xfer_fall) begin
      if (line_cnt_reg == gcd_pkg::LINE_FIELD_W'(LINES - 1)) begin
        line_cnt_reg <= gcd_pkg::LINE_FIELD_ZERO;
      end else begin
        line_cnt_reg <= line_cnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= gcd_pkg::PHASE_FIRST;
    end else if (marker_rise) begin
      if (phase_reg == gcd_pkg::PHASE_LAST) begin
        phase_reg <= gcd_pkg::PHASE_FIRST;
      end else begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // refresh fetch: one byte per free store cycle into the line buffer
  gcd_pkg::gcd_fetch_e              fetch_state_reg;
  logic [gcd_pkg::FETCH_IDX_W-1:0]  fetch_idx_reg;
  logic                             fetch_issue;
  logic                             fetch_start;
  logic [gcd_pkg::RAM_AW-1:0]       fetch_word;

  assign fetch_start = xfer_fall | marker_rise;
  // any selected host access stalls the fetch for that cycle
  assign fetch_issue = (fetch_state_reg == gcd_pkg::GCD_FETCH_BUSY)
                     & ~host_busy;
  assign fetch_word  = gcd_pkg::RAM_AW'(line_cnt_reg) * gcd_pkg::RAM_AW'(BYTES)
                     + gcd_pkg::RAM_AW'(fetch_idx_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_state_reg <= gcd_pkg::GCD_FETCH_IDLE;
      fetch_idx_reg   <= 6'h00;
    end else begin
      case (fetch_state_reg)
        gcd_pkg::GCD_FETCH_IDLE: begin
          if (fetch_start) begin
            fetch_state_reg <= gcd_pkg::GCD_FETCH_BUSY;
            fetch_idx_reg   <= 6'h00;
          end
        end
        gcd_pkg::GCD_FETCH_BUSY: begin
          if (fetch_start) begin
            fetch_idx_reg <= 6'h00;
          end else if (fetch_issue) begin
            if (fetch_idx_reg == gcd_pkg::FETCH_IDX_W'(BYTES - 1)) begin
              fetch_state_reg <= gcd_pkg::GCD_FETCH_IDLE;
            end else begin
              fetch_idx_reg <= fetch_idx_reg + 6'h01;
            end
          end
        end
        default: begin
          fetch_state_reg <= gcd_pkg::GCD_FETCH_IDLE;
          fetch_idx_reg   <= 6'h00;
        end
      endcase
    end
  end

  // store arbitration
  gcd_pkg::gcd_ram_req_s     ram_req;
  logic [gcd_pkg::DATA_W-1:0] ram_rdata;

  always_comb begin
    if (host_busy) begin
      ram_req.wr    = host_wr;
      ram_req.addr  = host_word;
      ram_req.wdata = host_req.wdata;
    end else begin
      ram_req.wr    = 1'b0;
      ram_req.addr  = fetch_word;
      ram_req.wdata = host_req.wdata;
    end
  end

  gcd_ram #(
    .WORDS (LINES * BYTES)
  ) u_ram (
    .clk   (clk),
    .rst   (rst),
    .req   (ram_req),
    .rdata (ram_rdata)
  );

  // read return tracking
  logic                            host_rd_d_reg;
  logic                            fetch_rd_d_reg;
  logic [gcd_pkg::FETCH_IDX_W-1:0] fetch_idx_d_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_rd_d_reg   <= 1'b0;
      fetch_rd_d_reg  <= 1'b0;
      fetch_idx_d_reg <= 6'h00;
    end else begin
      host_rd_d_reg   <= host_rd;
      fetch_rd_d_reg  <= fetch_issue & ~fetch_start;
      fetch_idx_d_reg <= fetch_idx_reg;
    end
  end

  // host data bus: driven only in the cycle after a selected read cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= host_rd;
      if (host_rd_d_reg) begin
        host_data_out <= ram_rdata;
      end
    end
  end

  // dither the fetched byte: leftmost pixel in the top bit pair
  logic [PPB-1:0] byte_on;

  for (genvar j = 0; j < PPB; j++) begin : g_frc
    gcd_frc_pixel u_frc (
      .gray  (ram_rdata[gcd_pkg::DATA_W-1-BPP*j -: BPP]),
      .phase (phase_reg),
      .on    (byte_on[j])
    );
  end

  // line buffer holds dithered on/off bits, output latch the shown line
  logic [PIXELS-1:0] line_buf_reg;
  logic [PIXELS-1:0] out_latch_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_buf_reg <= '0;
    end else if (fetch_rd_d_reg) begin
      for (int j = 0; j < PPB; j++) begin
        line_buf_reg[int'(fetch_idx_d_reg) * PPB + j] <= byte_on[j];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_latch_reg   <= '0;
      refresh_overrun <= 1'b0;
    end else if (xfer_fall) begin
      out_latch_reg <= line_buf_reg;
      // a fetch still running means the host held the store too long
      refresh_overrun <= (fetch_state_reg == gcd_pkg::GCD_FETCH_BUSY)
                       | fetch_rd_d_reg;
    end
  end

  // column drive level per output
  function automatic gcd_pkg::gcd_level_e drive_level(
    input logic on,
    input logic phase,
    input logic blank_n
  );
    gcd_pkg::gcd_level_e lvl;
    lvl = gcd_pkg::GCD_SELECT_HIGH;
    if (!blank_n) begin
      lvl = gcd_pkg::GCD_SELECT_HIGH;
    end else if (phase) begin
      lvl = on ? gcd_pkg::GCD_SELECT_HIGH
               : gcd_pkg::GCD_DESELECT_HIGH;
    end else begin
      lvl = on ? gcd_pkg::GCD_SELECT_LOW
               : gcd_pkg::GCD_DESELECT_LOW;
    end
    return lvl;
  endfunction : drive_level

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      column_outputs <= '0;
    end else begin
      for (int i = 0; i < PIXELS; i++) begin
        // mirror only the output order; the address map stays put
        column_outputs[i*2 +: 2] <= drive_level(
          column_order_reverse ? out_latch_reg[PIXELS-1-i]
                               : out_latch_reg[i],
          ac_phase, display_blank_n);
      end
    end
  end

endmodule : gcd_column_driver
`default_nettype wire

// ### bench/gcd_column_driver_asserts.sv
// checker: port-level properties of the grayscale column driver
`timescale 1ns/1ps
`default_nettype none
module gcd_column_driver_asserts #(
  parameter int PIXELS = gcd_pkg::PIXELS,
  parameter int LINES  = gcd_pkg::LINES
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire gcd_pkg::gcd_host_req_s host_req,
  input wire logic [7:0]             host_data_out,
  input wire logic                   host_data_oe,
  input wire logic                   id_select_bit0,
  input wire logic                   id_select_bit1,
  input wire logic                   column_order_reverse,
  input wire logic                   frame_start_marker,
  input wire logic                   line_transfer_clock,
  input wire logic                   ac_phase,
  input wire logic                   display_blank_n,
  input wire logic [PIXELS*2-1:0]    column_outputs,
  input wire logic                   refresh_overrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [8:0]        lf;
  logic [6:0]        cf;
  logic [2:0]        ctl_q;
  logic              rd_hit, ltc_q, xfer, ctl_chg;
  logic [PIXELS-1:0] lsbs;
  // unsigned wrap makes addresses below a window base miss too
  always_comb begin
    lf = host_req.addr[15:7]
         - (id_select_bit1 ? gcd_pkg::LINE_WINDOW_BASE : 9'h000);
    cf = host_req.addr[6:0]
         - (id_select_bit0 ? gcd_pkg::COL_WINDOW_BASE : 7'h00);
    rd_hit = !host_req.cs_n && lf < LINES && cf < PIXELS / 4
             && host_req.we_n && !host_req.oe_n;
    for (int i = 0; i < PIXELS; i++)
      lsbs[i] = column_outputs[2*i];
  end
  always_ff @(posedge clk) begin
    ltc_q <= line_transfer_clock;
    ctl_q <= {display_blank_n, ac_phase, column_order_reverse};
  end
  assign xfer    = ltc_q && !line_transfer_clock;
  assign ctl_chg = ctl_q != {display_blank_n, ac_phase, column_order_reverse};
  a_blank_forces_high: assert property (
    !display_blank_n |=> column_outputs == '0) else $error("blank ignored");
  a_oe_needs_select: assert property (
    host_req.cs_n |=> !host_data_oe) else $error("bus driven unselected");
  a_oe_tracks_read: assert property (
    host_data_oe == $past(rd_hit)) else $error("bus enable off read");
  a_data_after_read: assert property (
    $changed(host_data_out) |-> $past(host_data_oe))
    else $error("read data moved");
  a_cols_on_transfer: assert property (
    $changed(column_outputs) |-> $past(xfer, 2) || $past(ctl_chg)
                                 || $past(rst, 2))
    else $error("columns moved between transfers");
  a_overrun_on_transfer: assert property (
    $changed(refresh_overrun) |-> $past(xfer) || $past(xfer, 2))
    else $error("overrun moved between transfers");
  a_ac_high_level: assert property (
    (display_blank_n && ac_phase) [*2] |-> lsbs == '0)
    else $error("polarity wrong, phase high");
  a_ac_low_level: assert property (
    (display_blank_n && !ac_phase) [*2] |-> lsbs == '1)
    else $error("polarity wrong, phase low");
  c_read: cover property (rd_hit ##1 host_data_oe);
  c_transfer: cover property (xfer ##2 $changed(column_outputs));
  c_overrun: cover property ($rose(refresh_overrun));
endmodule : gcd_column_driver_asserts
bind gcd_column_driver gcd_column_driver_asserts #(
  .PIXELS(PIXELS), .LINES(LINES)) u_asserts (
  .clk(clk), .rst(rst), .host_req(host_req), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe), .id_select_bit0(id_select_bit0),
  .id_select_bit1(id_select_bit1), .ac_phase(ac_phase),
  .column_order_reverse(column_order_reverse),
  .frame_start_marker(frame_start_marker),
  .line_transfer_clock(line_transfer_clock),
  .display_blank_n(display_blank_n), .column_outputs(column_outputs),
  .refresh_overrun(refresh_overrun));
`default_nettype wire

// ### bench/gcd_host_model.sv
// host model: asynchronous sram-style master on the draw port
`timescale 1ns/1ps
`default_nettype none
module gcd_host_model (
  input  wire logic                  clk,
  output var gcd_pkg::gcd_host_req_s req,
  input  wire logic [7:0]            rdata,
  input  wire logic                  oe
);
  initial req = {3'h7, 16'h0000, 8'h00};
  // released data lines show the inverse of the last value
  task automatic idle();
    @(negedge clk);
    req = {3'h7, req.addr, ~req.wdata};
  endtask : idle
  // back-to-back calls keep the strobe low: a burst
  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    input logic cs_n);
    @(negedge clk);
    req = {cs_n, 2'h1, a, v};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    @(negedge clk);
    req = {1'b0, 2'h2, a, ~req.wdata};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      #1 ok = oe;
    end
    // data lands one edge after the enable: keep the strobe low until then
    @(posedge clk);
    #1 ok = ok & oe;
    d = rdata;
    idle();
  endtask : rd
endmodule : gcd_host_model
`default_nettype wire

// ### bench/gcd_column_driver_tb_top.sv
// testbench: draw port, identity windows, refresh, dither, drive levels
`timescale 1ns/1ps
`default_nettype none
module gcd_column_driver_tb_top;
  logic                   clk, rst, id0, id1, rev, mark, ltc, ac, blank_n;
  logic                   doe, ovr, ok;
  logic [7:0]             dout, d;
  logic [319:0]           cols;
  gcd_pkg::gcd_host_req_s hreq;
  int                     mismatches, tests_run;
  logic [15:0] wa [5] = '{16'h0000, 16'h0027, 16'h0080, 16'h77a7, 16'h0001};
  logic [7:0]  wd [5] = '{8'h1b, 8'h1b, 8'hff, 8'h5a, 8'h96};
  gcd_column_driver dut (.clk(clk), .rst(rst), .host_req(hreq),
    .host_data_out(dout), .host_data_oe(doe), .id_select_bit0(id0),
    .id_select_bit1(id1), .column_order_reverse(rev),
    .frame_start_marker(mark), .line_transfer_clock(ltc), .ac_phase(ac),
    .display_blank_n(blank_n), .column_outputs(cols),
    .refresh_overrun(ovr));
  gcd_host_model host (.clk(clk), .req(hreq), .rdata(dout), .oe(doe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] qa(input int k);
    return {k[1] ? 9'h100 : 9'h000, k[0] ? 7'h40 : 7'h00};
  endfunction : qa
  function automatic logic [1:0] lvl(input int g, input int ph, input logic a);
    logic on;
    on = g == 3 || (g == 2 && ph < 2) || (g == 1 && ph == 0);
    return a ? (on ? 2'h0 : 2'h2) : (on ? 2'h1 : 2'h3);
  endfunction : lvl
  // bytes 0 and 39 of line 0 hold one ramp, so columns 0..3 serve both orders
  task automatic check_cols(input int ph);
    logic [7:0] e;
    for (int i = 0; i < 4; i++)
      e[2*i+1 -: 2] = lvl(rev ? 3 - i : i, ph, ac);
    check(16'(cols[7:0]), 16'(e));
  endtask : check_cols
  task automatic xfer(input int n);
    @(negedge clk) ltc = 1'b1;
    repeat (n) @(negedge clk);
    ltc  = 1'b0;
    mark = 1'b0;
    repeat (4) @(negedge clk);
  endtask : xfer
  // fetch needs 41 quiet cycles; 46 leaves margin before the transfer
  task automatic frame();
    @(negedge clk) mark = 1'b1;
    repeat (46) @(negedge clk);
    xfer(2);
  endtask : frame
  initial begin
    {rst, id0, id1, rev, mark, ltc, ac, blank_n} = 8'h83;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int i = 0; i < 5; i++)
      host.wr(wa[i], wd[i], 1'b0);
    host.wr(16'h0001, 8'h3c, 1'b1);
    host.wr(16'h0040, 8'h3c, 1'b0);
    host.idle();
    for (int i = 0; i < 5; i++) begin
      host.rd(wa[i], d, ok);
      check(16'({ok, d}), 16'({1'b1, wd[i]}));
    end
    host.rd(16'h0040, d, ok);
    check(16'(ok), 16'h0000);
    $display("burst test done");
    for (int k = 0; k < 4; k++) begin
      @(negedge clk) {id1, id0} = 2'(k);
      host.rd(qa(k), d, ok);
      check(16'({ok, d}), 16'h011b);
      host.rd(qa(3 - k), d, ok);
      check(16'(ok), 16'h0000);
    end
    @(negedge clk) {id1, id0} = 2'h0;
    $display("identity test done");
    for (int k = 0; k < 3; k++) begin
      frame();
      check_cols((k + 1) % 3);
    end
    for (int m = 0; m < 4; m++) begin
      @(negedge clk) {ac, rev} = 2'(m);
      repeat (2) @(negedge clk);
      check_cols(0);
    end
    @(negedge clk) blank_n = 1'b0;
    repeat (2) @(negedge clk);
    check(16'(cols != '0), 16'h0000);
    @(negedge clk) {blank_n, ac, rev} = 3'h4;
    xfer(45);
    check(16'({ovr, cols[7:0]}), 16'h0055);
    $display("display test done");
    @(negedge clk) mark = 1'b1;
    host.wr(16'h0002, 8'he4, 1'b0);
    host.wr(16'h0003, 8'he4, 1'b0);
    host.idle();
    xfer(2);
    check(16'(ovr), 16'h0001);
    host.rd(16'h0002, d, ok);
    check(16'({ok, d}), 16'h01e4);
    $display("overrun test done");
    wrap_up();
  end
endmodule : gcd_column_driver_tb_top
`default_nettype wire
